// ==== rtl/tap_regs.svh ====
// Constants for the boundary-scan test access port
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH

// Instruction codes
`define INSTR_EXTEST 4'h0
`define INSTR_SAMPLE 4'h1
`define INSTR_IDCODE 4'h2
`define INSTR_HIGHZ 4'h4
`define INSTR_BYPASS 4'hF

// Instruction capture pattern, low two bits fixed at 01
`define IR_CAPTURE 4'h1

// Identification word fields
`define ID_VERSION 4'h3 // Arbitrary value
`define ID_PART 16'h5A17 // Arbitrary value
`define ID_MAKER 11'h1C6 // Arbitrary value
`define ID_LSB_ONE 1'h1

// Test-logic-reset after this many TMS-high edges
`define TMS_RESET_COUNT 3'h5

// Pin levels held by the synchroniser in reset, fields tck, tms, tdi,
// trst_n: clock low, select high, data low, reset pin released
`define PINS_IDLE 4'h5

// Default length of the boundary chain
`define BSR_LEN 8

`endif

// ==== rtl/tap_pkg.sv ====
// Types shared by the test access port
package tap_pkg;

  // Sixteen controller states
  typedef enum logic [3:0] {
    st_reset, st_idle, st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr,
    st_pause_dr, st_exit2_dr, st_upd_dr, st_sel_ir, st_cap_ir,
    st_shift_ir, st_exit1_ir, st_pause_ir, st_exit2_ir, st_upd_ir
  } tap_state_e;

  // Synchronised tester pins
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } tap_pins_s;

endpackage

// ==== rtl/tap_sync.sv ====
// Two-stage synchroniser for the tester pins
`timescale 1ns/1ps
`default_nettype none
`include "tap_regs.svh"
module tap_sync
  import tap_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Raw pins and synchronised copy
  input wire tap_pins_s raw,
  output var tap_pins_s synced
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    tap_pins_s s1; // First stage, read only by second
    tap_pins_s s2; // Second stage
  } sync_s;

  sync_s state_q;
  sync_s state_d;

  // Shift pins through both stages
  always_comb begin
    state_d = state_q;
    state_d.s1 = raw;
    state_d.s2 = state_q.s1;
  end

  // Register the copy
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      // Idle pin levels, so no false pin reset follows a system reset
      state_q.s1 <= `PINS_IDLE;
      state_q.s2 <= `PINS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign synced = state_q.s2;

endmodule
`default_nettype wire

// ==== rtl/tap_controller.sv ====
// Boundary-scan test access port controller with its scan registers
`timescale 1ns/1ps
`default_nettype none
`include "tap_regs.svh"

module tap_controller
  import tap_pkg::*;
#(
  parameter logic [3:0] ID_VERSION = `ID_VERSION, // Arbitrary value
  parameter logic [15:0] ID_PART = `ID_PART, // Arbitrary value
  parameter logic [10:0] ID_MAKER = `ID_MAKER // Arbitrary value
)
(
  // System clock and reset
  input wire logic clock,
  input wire logic reset,
  // Tester pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  // Boundary cells
  input wire logic [`BSR_LEN-1:0] pin_sample,
  output logic [`BSR_LEN-1:0] pin_drive,
  output logic pin_test_mode,
  // Core control
  output logic outputs_disable,
  output logic queue_enable
);

  // ----------------------------------------
  // Synchronised pins
  // ----------------------------------------
  tap_pins_s raw; // Raw pins grouped
  tap_pins_s pins; // Pins after two flops
  assign raw = '{tck: tck, tms: tms, tdi: tdi, trst_n: trst_n};

  tap_sync u_sync (
    .clock(clock),
    .reset(reset),
    .raw(raw),
    .synced(pins)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    tap_state_e fsm; // Controller state
    logic tck_prev; // TCK one sample ago
    logic [3:0] ir_shift; // Instruction shifter
    logic [3:0] ir_hold; // Active instruction
    logic bypass; // Bypass stage
    logic [31:0] id_shift; // Identification shifter
    logic [`BSR_LEN-1:0] bsr_shift; // Boundary shifter
    logic [`BSR_LEN-1:0] bsr_upd; // Boundary update cells
    logic tdo; // Serial output, changes on falling TCK
    logic tdo_oe; // Output enable
    logic was_reset; // Controller has been reset once
    logic [2:0] tms_ones; // Run of TMS-high edges
    logic [`BSR_LEN-1:0] pin_meta; // Boundary inputs, first stage
    logic [`BSR_LEN-1:0] pin_sync; // Boundary inputs, second stage
  } tap_s;

  tap_s state_q;
  tap_s state_d;

  // Identification word assembly
  function automatic logic [31:0] id_word();
    id_word = {ID_VERSION, ID_PART, ID_MAKER, `ID_LSB_ONE};
  endfunction

  // Next controller state for a TMS level
  function automatic tap_state_e next_state(tap_state_e s, logic m);
    case (s)
      st_reset: next_state = m ? st_reset : st_idle;
      st_idle: next_state = m ? st_sel_dr : st_idle;
      st_sel_dr: next_state = m ? st_sel_ir : st_cap_dr;
      st_cap_dr: next_state = m ? st_exit1_dr : st_shift_dr;
      st_shift_dr: next_state = m ? st_exit1_dr : st_shift_dr;
      st_exit1_dr: next_state = m ? st_upd_dr : st_pause_dr;
      st_pause_dr: next_state = m ? st_exit2_dr : st_pause_dr;
      st_exit2_dr: next_state = m ? st_upd_dr : st_shift_dr;
      st_upd_dr: next_state = m ? st_sel_dr : st_idle;
      st_sel_ir: next_state = m ? st_reset : st_cap_ir;
      st_cap_ir: next_state = m ? st_exit1_ir : st_shift_ir;
      st_shift_ir: next_state = m ? st_exit1_ir : st_shift_ir;
      st_exit1_ir: next_state = m ? st_upd_ir : st_pause_ir;
      st_pause_ir: next_state = m ? st_exit2_ir : st_pause_ir;
      st_exit2_ir: next_state = m ? st_upd_ir : st_shift_ir;
      st_upd_ir: next_state = m ? st_sel_dr : st_idle;
      default: next_state = st_reset;
    endcase
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic tck_rise; // TCK rising edge seen
  logic tck_fall; // TCK falling edge seen
  logic sel_bsr; // Boundary chain in path
  logic sel_id; // Identification in path
  logic sel_byp; // Bypass in path

  always_comb begin
    tck_rise = pins.tck & ~state_q.tck_prev;
    tck_fall = ~pins.tck & state_q.tck_prev;
    sel_bsr = (state_q.ir_hold == `INSTR_EXTEST) ||
              (state_q.ir_hold == `INSTR_SAMPLE);
    sel_id = (state_q.ir_hold == `INSTR_IDCODE);
    sel_byp = !sel_bsr && !sel_id;
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.tck_prev = pins.tck;
    // Boundary inputs pass two flops before the capture reads them
    state_d.pin_meta = pin_sample;
    state_d.pin_sync = state_q.pin_meta;
    if (!pins.trst_n) begin
      // Pin reset forces the reset state and identification instruction, and turns off the output enable
      state_d.fsm = st_reset;
      state_d.ir_hold = `INSTR_IDCODE;
      state_d.was_reset = 1'b1;
      state_d.tms_ones = '0;
      state_d.tdo_oe = 1'b0;
    end else if (tck_rise) begin
      // Every transition except pin and system reset on a rising TCK edge
      state_d.fsm = next_state(state_q.fsm, pins.tms);
      // Count TMS-high run
      if (pins.tms) begin
        if (state_q.tms_ones < `TMS_RESET_COUNT) begin
          state_d.tms_ones = state_q.tms_ones + 3'h1;
        end
      end else begin
        state_d.tms_ones = '0;
      end
      case (state_q.fsm)
        st_cap_ir: state_d.ir_shift = `IR_CAPTURE;
        st_shift_ir: begin
          // LSB leaves first toward TDO
          state_d.ir_shift = {pins.tdi,
                              state_q.ir_shift[3:1]};
        end
        st_cap_dr: begin
          if (sel_byp) state_d.bypass = 1'b0;
          if (sel_id) state_d.id_shift = id_word();
          if (sel_bsr) state_d.bsr_shift = state_q.pin_sync;
        end
        st_shift_dr: begin
          if (sel_byp) state_d.bypass = pins.tdi;
          if (sel_id) begin
            state_d.id_shift = {pins.tdi, state_q.id_shift[31:1]};
          end
          if (sel_bsr) begin
            state_d.bsr_shift = {pins.tdi,
                                 state_q.bsr_shift[`BSR_LEN-1:1]};
          end
        end
        // Pause states keep the shifters unchanged
        default: begin
          state_d.ir_shift = state_q.ir_shift;
        end
      endcase
      // Sticky reset marker once the machine sits in reset
      if (next_state(state_q.fsm, pins.tms) == st_reset) begin
        state_d.was_reset = 1'b1;
      end
    end else if (tck_fall) begin
      // Falling edge: update stages and serial output
      case (state_q.fsm)
        st_reset: state_d.ir_hold = `INSTR_IDCODE;
        st_upd_ir: state_d.ir_hold = state_q.ir_shift;
        st_upd_dr: begin
          if (sel_bsr) state_d.bsr_upd = state_q.bsr_shift;
        end
        default: state_d.ir_hold = state_q.ir_hold;
      endcase
      state_d.tdo_oe = (state_q.fsm == st_shift_ir) ||
                       (state_q.fsm == st_shift_dr);
      if (state_q.fsm == st_shift_ir) begin
        state_d.tdo = state_q.ir_shift[0];
      end else if (sel_id) begin
        state_d.tdo = state_q.id_shift[0];
      end else if (sel_bsr) begin
        state_d.tdo = state_q.bsr_shift[0];
      end else begin
        state_d.tdo = state_q.bypass;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      // System reset puts the controller in idle with bypass, not in its reset state
      state_q <= '0;
      state_q.fsm <= st_idle;
      state_q.ir_hold <= `INSTR_BYPASS;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    tdo = state_q.tdo;
    tdo_oe = state_q.tdo_oe;
    pin_drive = state_q.bsr_upd;
    // Test logic is inactive in reset and idle unless instructed
    pin_test_mode = (state_q.ir_hold == `INSTR_EXTEST) &&
                    (state_q.fsm != st_reset);
    outputs_disable = (state_q.ir_hold == `INSTR_HIGHZ) &&
                      (state_q.fsm != st_reset);
    queue_enable = state_q.was_reset;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_tms_reset_run: assert property (
    @(posedge clock) disable iff (reset)
    (tck_rise && pins.tms && pins.trst_n &&
     state_q.tms_ones == `TMS_RESET_COUNT - 3'h1)
    |=> (state_q.fsm == st_reset))
    else $error("five TMS-high edges did not reach reset");

  chk_queue_hold: assert property (
    @(posedge clock) disable iff (reset)
    $rose(queue_enable) |-> (state_q.fsm == st_reset))
    else $error("queue enabled without controller reset");

  chk_no_move_idle: assert property (
    @(posedge clock) disable iff (reset)
    (!tck_rise && pins.trst_n) |=> $stable(state_q.fsm))
    else $error("state moved without rising TCK");

  chk_sel_ir_exit: assert property (
    @(posedge clock) disable iff (reset)
    (tck_rise && pins.trst_n && state_q.fsm == st_sel_ir && pins.tms)
    |=> state_q.fsm == st_reset)
    else $error("select-IR with TMS high missed reset");

  chk_ir_capture: assert property (
    @(posedge clock) disable iff (reset)
    (tck_rise && pins.trst_n && state_q.fsm == st_cap_ir)
    |=> state_q.ir_shift[1:0] == 2'b01)
    else $error("capture pattern low bits not 01");

  chk_pause_hold: assert property (
    @(posedge clock) disable iff (reset)
    (state_q.fsm == st_pause_ir && pins.trst_n) |=> $stable(state_q.ir_shift))
    else $error("instruction shifter changed in pause");

  chk_ir_update: assert property (
    @(posedge clock) disable iff (reset)
    (tck_fall && pins.trst_n && state_q.fsm == st_upd_ir)
    |=> state_q.ir_hold == $past(state_q.ir_shift))
    else $error("instruction not latched in update");

  chk_bypass_clear: assert property (
    @(posedge clock) disable iff (reset)
    (tck_rise && pins.trst_n && state_q.fsm == st_cap_dr && sel_byp)
    |=> !state_q.bypass)
    else $error("bypass stage not cleared on capture");

  chk_highz_out: assert property (
    @(posedge clock) disable iff (reset)
    (state_q.ir_hold == `INSTR_HIGHZ && state_q.fsm != st_reset)
    |-> outputs_disable && sel_byp)
    else $error("high-impedance instruction not honoured");

endmodule
`default_nettype wire

// ==== dv/scan_tester.sv ====
// Behavioural boundary-scan tester driving the test pins
`timescale 1ns/1ps
`default_nettype none
module scan_tester (
  // Pacing clock
  input wire logic clock,
  // Test pins
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo
);
  // Pins idle with the test clock low
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
    trst_n = 1'h1;
  end

  // --------------------------------------------
  // One 160 ns test clock cycle
  // --------------------------------------------
  // Serial out is taken just before the fall
  task automatic step(input logic m, input logic d, output logic q);
    tck <= 1'h0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clock);
    tck <= 1'h1;
    repeat (4) @(posedge clock);
    q = tdo;
  endtask

  // Five select-high edges, then idle
  task automatic reset_tap();
    logic q;
    for (int i = 0; i < 5; i++) step(1'h1, 1'($urandom), q);
    step(1'h0, 1'($urandom), q);
  endtask

  // Reset pin pulsed low, then idle
  task automatic pulse_trst();
    logic q;
    trst_n <= 1'h0;
    repeat (4) @(posedge clock);
    trst_n <= 1'h1;
    repeat (4) @(posedge clock);
    step(1'h0, 1'($urandom), q);
  endtask

  // Idle to idle scan, least significant bit first
  // Optional halt halfway; serial in is noise outside shifting
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      input logic pz, output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'h1, 1'($urandom), q);
    if (ir) step(1'h1, 1'($urandom), q);
    step(1'h0, 1'($urandom), q);
    step(1'h0, 1'($urandom), q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || (pz && i == n / 2 - 1), din[i], q);
      dout[i] = q;
      // Halt, hold, resume shifting
      if (pz && i == n / 2 - 1) begin
        step(1'h0, 1'($urandom), q);
        step(1'h0, 1'($urandom), q);
        step(1'h1, 1'($urandom), q);
        step(1'h0, 1'($urandom), q);
      end
    end
    step(1'h1, 1'($urandom), q);
    step(1'h0, 1'($urandom), q);
  endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the test access port controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tap_pkg::*;
  // Arbitrary identification fields
  localparam logic [3:0] VER = 4'hA;
  localparam logic [15:0] PART = 16'hC0DE;
  localparam logic [10:0] MAKER = 11'h2A5;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic [7:0] pin_sample = 8'h00;
  logic [7:0] pin_drive;
  logic pin_test_mode, outputs_disable, queue_enable;
  int fail_count = 0;
  int check_count = 0;
  logic [31:0] got;
  logic [31:0] d;
  logic [3:0] code;
  int oe_count = 0;

  // Edges with serial output enabled: one test clock per shifted bit
  always @(posedge clock) begin
    if (tdo_oe === 1'h1) oe_count <= oe_count + 1;
  end

  // 50 MHz clock
  always #10 clock = ~clock;

  tap_controller #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER))
    tap_controller_i (.clock(clock), .reset(reset), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
    .pin_sample(pin_sample), .pin_drive(pin_drive),
    .pin_test_mode(pin_test_mode), .outputs_disable(outputs_disable),
    .queue_enable(queue_enable));

  scan_tester scan_tester_i (.clock(clock), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

  // ------------------------------------------
  // Helpers
  // ------------------------------------------
  // Compare and count
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
      fail_count++;
    end
  endtask

  // Expected identification word
  function automatic logic [31:0] id_word();
    return {VER, PART, MAKER, 1'h1};
  endfunction

  // Bypass output: captured zero, then input one bit late
  function automatic logic [31:0] byp_word(input logic [31:0] v);
    return {24'h000000, v[6:0], 1'h0};
  endfunction

  // Instruction load, with capture pattern check
  task automatic load_ir(input logic [3:0] c);
    logic [31:0] o;
    int m;
    m = oe_count;
    scan_tester_i.scan(1'h1, 4, {28'h0, c}, 1'($urandom), o);
    check(o[1:0], 2'h1);
    check(oe_count - m, 32'h20);
    check(tdo_oe, 1'h0);
  endtask

  // Data scan of n bits
  task automatic dr(input int n, input logic [31:0] v);
    int m;
    m = oe_count;
    scan_tester_i.scan(1'h0, n, v, 1'($urandom), got);
    check(oe_count - m, n * 32'h8);
    check(tdo_oe, 1'h0);
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial begin
    void'($urandom(50));
    repeat (10) @(posedge clock);
    reset <= 1'h0;
    repeat (4) @(posedge clock);
    check(queue_enable, 1'h0);
    scan_tester_i.reset_tap();
    check(queue_enable, 1'h1);
    dr(32, $urandom);
    check(got, id_word());
    // Bypass, high-impedance and undecoded codes
    for (int k = 0; k < 6; k++) begin
      code = (k < 2) ? (k ? 4'h4 : 4'hF) : 4'($urandom_range(3, 15));
      load_ir(code);
      check(outputs_disable, code == 4'h4);
      check(pin_test_mode, 1'h0);
      d = $urandom;
      dr(8, d);
      check(got, byp_word(d));
      check(queue_enable, 1'h1);
    end
    // Sample pins and preload, then drive them
    pin_sample <= 8'($urandom);
    d = $urandom;
    load_ir(4'h1);
    dr(8, d);
    check(got, {24'h0, pin_sample});
    check(pin_test_mode, 1'h0);
    load_ir(4'h0);
    check(pin_test_mode, 1'h1);
    check(pin_drive, d[7:0]);
    // Reset pin leaves test mode, identification back
    scan_tester_i.pulse_trst();
    check(pin_test_mode, 1'h0);
    dr(32, $urandom);
    check(got, id_word());
    // Select-high reset from mid-test
    load_ir(4'h4);
    check(outputs_disable, 1'h1);
    scan_tester_i.reset_tap();
    check(outputs_disable, 1'h0);
    // Second system reset blocks the queue again
    reset <= 1'h1;
    repeat (3) @(posedge clock);
    reset <= 1'h0;
    repeat (4) @(posedge clock);
    check(queue_enable, 1'h0);
    conclude();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (30000) @(posedge clock);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
